// ==== shared/fss_pkg.sv ====
/*
 Constants and types for the flash service and protection block.
 Assumes an APB master with 32-bit data, and a flash array controller on the same clock.
*/
package fss_pkg;
   // APB word offsets
   localparam logic [11:0] ADDR_FUNC   = 12'h000;
   localparam logic [11:0] ADDR_PARAM  = 12'h004;
   localparam logic [11:0] ADDR_VALUE  = 12'h008;
   localparam logic [11:0] ADDR_CTRL   = 12'h00C;
   localparam int          CTRL_START  = 0;
   localparam int          STAT_BUSY   = 0;
   localparam int          STAT_DONE   = 1;
   localparam int          STAT_ERR    = 2;
   localparam int          STAT_LVL_LO = 4;
   localparam int          STAT_LVL_HI = 6;

   // Function codes
   localparam logic [7:0] FN_PROG_ZERO  = 8'h90;
   localparam logic [7:0] FN_CHIP_ERASE = 8'h91;
   localparam logic [7:0] FN_PROG_CELL  = 8'h94;
   localparam logic [7:0] FN_ERASE_CELL = 8'h95;
   localparam logic [7:0] FN_READ_CELL  = 8'h96;
   localparam logic [7:0] MODE_RETURN   = 8'h55;
   localparam logic [7:0] MODE_RESET    = 8'hAA;

   // Block numbers in the high parameter byte
   localparam logic [7:0] BLK0_CODE = 8'h00;
   localparam logic [7:0] BLK1_CODE = 8'h20;
   localparam logic [7:0] BLK2_CODE = 8'h40;
   localparam logic [7:0] BLK3_CODE = 8'h80;
   localparam logic [7:0] BLK4_CODE = 8'hC0;
   localparam logic [7:0] BLK_LOW   = 8'h00;

   // Special cell addresses
   localparam logic [15:0] CELL_BSW_LO = 16'h0000;
   localparam logic [15:0] CELL_BSW_HI = 16'h0001;
   localparam logic [15:0] CELL_BV_LO  = 16'h0002;
   localparam logic [15:0] CELL_BV_HI  = 16'h0003;
   localparam logic [15:0] CELL_STATUS = 16'h0004;
   localparam logic [15:0] CELL_MFR    = 16'h0006;
   localparam logic [15:0] CELL_DEV1   = 16'h0007;
   localparam logic [15:0] CELL_DEV2   = 16'h0008;
   localparam logic [15:0] CELL_LOCK1  = 16'h000A;
   localparam logic [15:0] CELL_LOCK2  = 16'h000C;
   localparam logic [15:0] CELL_LOCK3  = 16'h000E;
   localparam int          LOCK_BIT    = 0;

   // Result bytes
   localparam logic [7:0] RES_PASS       = 8'h00;
   localparam logic [7:0] RES_BAD_FUNC   = 8'h01;
   localparam logic [7:0] RES_LOCKED     = 8'h02;
   localparam logic [7:0] RES_BAD_PARAM  = 8'h03;
   localparam logic [7:0] RES_FLASH_FAIL = 8'h04;
   localparam logic [7:0] ERASED         = 8'hFF;

   localparam logic [2:0] LVL_OPEN  = 3'h1;
   localparam logic [2:0] LVL_BLOCK = 3'h2;
   localparam logic [2:0] LVL_VERIF = 3'h3;
   localparam logic [2:0] LVL_FULL  = 3'h4;

   typedef enum logic [1:0] {FSS_IDLE, FSS_EXEC, FSS_WAIT} fss_state_t;
   typedef enum logic [0:0] {FSS_OP_ZERO_BLOCK, FSS_OP_CHIP_ERASE} fss_flash_op_t;

   typedef struct packed {
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
   } fss_apb_req_t;

   typedef struct packed {
      logic        pready;
      logic [31:0] prdata;
      logic        pslverr;
   } fss_apb_rsp_t;

   typedef struct packed {
      logic          req;
      fss_flash_op_t op;
      logic [2:0]    block;
   } fss_flash_cmd_t;

   typedef struct packed {
      logic done;
      logic fail;
   } fss_flash_rsp_t;
endpackage

// ==== verilog/fss_flash_service.sv ====
/*
 Flash service routines and lock-bit protection, reached over APB.
 Assumes the flash array controller runs on SYS_CLK and holds its done pulse one cycle.
*/
// Implementation choices: the APB register port and the register offsets.
//
// What this block does
// RULE1: Code 90h zeroes one block; block number in high byte bits 7:5. The code takes only 00h/20h/40h/80h/C0h, as blocks 0-4.
// RULE2: Program or erase ends with result byte 00 on pass, non-zero on fail.
// RULE3: Code 91h with mode 55h erases the chip, then returns.
// RULE4: Mode AAh erases the chip, then resets it; other modes are errors.
// RULE5: Code 94h programs special cells 0000h-0004h and lock cells 000Ah/Ch/Eh.
// RULE6: The caller programs at most two bits of a cell per operation.
// RULE7: Code 95h erases only special cells 0000h to 0004h.
// RULE8: Code 96h reads a cell; 0006h-0008h give maker and device identity.
// RULE9: Three independent lock bits in nonvolatile cells select the protection level. The code keeps them in registers that RST loads erased.
// RULE10: No lock bits set means level 1, no restrictions.
// RULE11: Level 2 refuses block erase and status byte or boot vector changes.
// RULE12: Level 3 adds a block on verification readout.
// RULE13: Level 4 adds a block on external execution.
// RULE14: Software sets lock bits only in the four defined combinations.
// RULE15: Full-chip erase proceeds whatever the lock bits hold.
// RULE16: Lock bits never stop programming of still unprogrammed bits. The code refuses any boot vector or status byte programming at level 2 and up.
// RULE17: Unknown function codes do nothing and report a non-zero result.
// RULE18: Refused operations leave flash unchanged and report a non-zero result.
`timescale 1ns/1ps
module fss_flash_service #(
   parameter logic [7:0] MFR_ID  = 8'h5A, // Arbitrary value
   parameter logic [7:0] DEV_ID1 = 8'h11, // Arbitrary value
   parameter logic [7:0] DEV_ID2 = 8'h22  // Arbitrary value
) (
   input  wire logic                    SYS_CLK,
   input  wire logic                    RST,
   input  wire fss_pkg::fss_apb_req_t   APB_REQ,
   output      fss_pkg::fss_apb_rsp_t   APB_RSP,
   output      fss_pkg::fss_flash_cmd_t FLASH_CMD,
   input  wire fss_pkg::fss_flash_rsp_t FLASH_RSP,
   output      logic                    CHIP_RESET,
   output      logic                    VERIFY_LOCK,
   output      logic                    EXT_EXEC_LOCK
);

   typedef struct packed {
      fss_pkg::fss_state_t     state;
      logic [7:0]              func;
      logic [15:0]             param;
      logic [7:0]              value;
      logic                    done;
      logic                    err;
      logic                    reset_after;
      logic [15:0][7:0]        cells;
      fss_pkg::fss_apb_rsp_t   rsp;
      fss_pkg::fss_flash_cmd_t cmd;
      logic                    chip_rst;
      logic                    verify_lock;
      logic                    ext_lock;
   } fss_regs_t;

   fss_regs_t r_reg;
   fss_regs_t r_next;

   // Level from the lock cells; a lock bit counts as set once programmed to zero
   function automatic logic [2:0] fss_level(input logic [15:0][7:0] c);
      logic l1;
      logic l2;
      logic l3;
      l1 = ~c[fss_pkg::CELL_LOCK1[3:0]][fss_pkg::LOCK_BIT];
      l2 = ~c[fss_pkg::CELL_LOCK2[3:0]][fss_pkg::LOCK_BIT];
      l3 = ~c[fss_pkg::CELL_LOCK3[3:0]][fss_pkg::LOCK_BIT];
      // Undefined mixes fall to the highest level whose bits are all present
      if (l1 && l2 && l3) begin // RULE13
         fss_level = fss_pkg::LVL_FULL;
      end else if (l1 && l2) begin // RULE12
         fss_level = fss_pkg::LVL_VERIF;
      end else if (l1) begin // RULE11
         fss_level = fss_pkg::LVL_BLOCK;
      end else begin
         fss_level = fss_pkg::LVL_OPEN; // RULE10
      end
   endfunction

   // Boot vector and status byte are the cells that level 2 freezes
   function automatic logic fss_guarded(input logic [15:0] a);
      fss_guarded = (a == fss_pkg::CELL_BV_LO) || (a == fss_pkg::CELL_BV_HI) ||
                    (a == fss_pkg::CELL_STATUS);
   endfunction

   function automatic logic fss_boot_cell(input logic [15:0] a);
      fss_boot_cell = (a == fss_pkg::CELL_BSW_LO) || (a == fss_pkg::CELL_BSW_HI) ||
                      fss_guarded(a);
   endfunction

   // Lock cells take programming at every level but are erased only by chip erase or by RST
   function automatic logic fss_lock_cell(input logic [15:0] a);
      fss_lock_cell = (a == fss_pkg::CELL_LOCK1) || (a == fss_pkg::CELL_LOCK2) ||
                      (a == fss_pkg::CELL_LOCK3);
   endfunction

   // Level 2 and up freeze the boot vector and status byte
   function automatic logic fss_frozen(input logic [15:0] a, input logic [2:0] l);
      fss_frozen = fss_guarded(a) && (l >= fss_pkg::LVL_BLOCK); // RULE11
   endfunction

   // Valid flag above a block index; only the five listed codes name a block
   function automatic logic [3:0] fss_block_code(input logic [7:0] h);
      case (h) // RULE1
         fss_pkg::BLK0_CODE: fss_block_code = {1'b1, 3'h0};
         fss_pkg::BLK1_CODE: fss_block_code = {1'b1, 3'h1};
         fss_pkg::BLK2_CODE: fss_block_code = {1'b1, 3'h2};
         fss_pkg::BLK3_CODE: fss_block_code = {1'b1, 3'h3};
         fss_pkg::BLK4_CODE: fss_block_code = {1'b1, 3'h4};
         default:            fss_block_code = {1'b0, 3'h0};
      endcase
   endfunction

   always_comb begin
      logic [2:0] lvl;
      logic [7:0] res;
      logic       fin;
      logic [2:0] blk;
      logic       blk_ok;
      logic [3:0] ci;
      lvl    = fss_level(r_reg.cells); // RULE9
      res    = fss_pkg::RES_PASS;
      fin    = 1'b0;
      blk    = 3'h0;
      blk_ok = 1'b1;
      ci     = r_reg.param[3:0];
      r_next = r_reg;
      r_next.rsp.pready   = 1'b0;
      r_next.rsp.pslverr  = 1'b0;
      r_next.chip_rst     = 1'b0;
      // Lock outputs lag the cells by one cycle; nothing outside needs them sooner
      r_next.verify_lock  = (lvl >= fss_pkg::LVL_VERIF); // RULE12
      r_next.ext_lock     = (lvl == fss_pkg::LVL_FULL); // RULE13

      // APB slave, one wait state so read data leaves a flip-flop
      if (APB_REQ.psel && APB_REQ.penable && !r_reg.rsp.pready) begin
         r_next.rsp.pready = 1'b1;
         r_next.rsp.prdata = 32'h0000_0000;
         case (APB_REQ.paddr)
            fss_pkg::ADDR_FUNC: begin
               r_next.rsp.prdata[7:0] = r_reg.func;
               if (APB_REQ.pwrite && r_reg.state == fss_pkg::FSS_IDLE) begin
                  r_next.func = APB_REQ.pwdata[7:0];
               end
            end
            fss_pkg::ADDR_PARAM: begin
               r_next.rsp.prdata[15:0] = r_reg.param;
               if (APB_REQ.pwrite && r_reg.state == fss_pkg::FSS_IDLE) begin
                  r_next.param = APB_REQ.pwdata[15:0];
               end
            end
            fss_pkg::ADDR_VALUE: begin
               r_next.rsp.prdata[7:0] = r_reg.value;
               if (APB_REQ.pwrite && r_reg.state == fss_pkg::FSS_IDLE) begin
                  r_next.value = APB_REQ.pwdata[7:0];
               end
            end
            fss_pkg::ADDR_CTRL: begin
               r_next.rsp.prdata[fss_pkg::STAT_BUSY] = (r_reg.state != fss_pkg::FSS_IDLE);
               r_next.rsp.prdata[fss_pkg::STAT_DONE] = r_reg.done;
               r_next.rsp.prdata[fss_pkg::STAT_ERR]  = r_reg.err;
               r_next.rsp.prdata[fss_pkg::STAT_LVL_HI:fss_pkg::STAT_LVL_LO] = lvl;
               // A start while busy is dropped rather than queued
               if (APB_REQ.pwrite && APB_REQ.pwdata[fss_pkg::CTRL_START] &&
                   r_reg.state == fss_pkg::FSS_IDLE) begin
                  r_next.state = fss_pkg::FSS_EXEC;
                  r_next.done  = 1'b0;
                  r_next.err   = 1'b0;
               end
            end
            // Unmapped offsets answer with an error and touch nothing
            default: begin
               r_next.rsp.pslverr = 1'b1;
            end
         endcase
      end

      case (r_reg.state)
         fss_pkg::FSS_IDLE: begin
         end
         fss_pkg::FSS_EXEC: begin
            fin = 1'b1;
            case (r_reg.func)
               fss_pkg::FN_PROG_ZERO: begin
                  {blk_ok, blk} = fss_block_code(r_reg.param[15:8]); // RULE1
                  if (lvl >= fss_pkg::LVL_BLOCK) begin
                     res = fss_pkg::RES_LOCKED; // RULE11 RULE18
                  end else if (!blk_ok || r_reg.param[7:0] != fss_pkg::BLK_LOW) begin
                     res = fss_pkg::RES_BAD_PARAM; // RULE1
                  end else begin
                     fin                = 1'b0;
                     r_next.cmd.req     = 1'b1;
                     r_next.cmd.op      = fss_pkg::FSS_OP_ZERO_BLOCK;
                     r_next.cmd.block   = blk;
                     r_next.state       = fss_pkg::FSS_WAIT;
                  end
               end
               fss_pkg::FN_CHIP_ERASE: begin
                  // No level check here on purpose
                  if (r_reg.value == fss_pkg::MODE_RETURN ||
                      r_reg.value == fss_pkg::MODE_RESET) begin // RULE15
                     fin                = 1'b0;
                     r_next.cmd.req     = 1'b1;
                     r_next.cmd.op      = fss_pkg::FSS_OP_CHIP_ERASE;
                     r_next.cmd.block   = 3'h0;
                     r_next.reset_after = (r_reg.value == fss_pkg::MODE_RESET); // RULE4
                     r_next.state       = fss_pkg::FSS_WAIT;
                  end else begin
                     res = fss_pkg::RES_BAD_PARAM; // RULE4
                  end
               end
               fss_pkg::FN_PROG_CELL: begin
                  if (!(fss_boot_cell(r_reg.param) || fss_lock_cell(r_reg.param))) begin
                     res = fss_pkg::RES_BAD_PARAM; // RULE5
                  end else if (fss_frozen(r_reg.param, lvl)) begin
                     res = fss_pkg::RES_LOCKED; // RULE11 RULE18
                  end else begin
                     // Programming only clears bits; locks block it only for the frozen boot vector and status byte
                     r_next.cells[ci] = r_reg.cells[ci] & r_reg.value; // RULE5 RULE16
                  end
               end
               fss_pkg::FN_ERASE_CELL: begin
                  if (!fss_boot_cell(r_reg.param)) begin
                     res = fss_pkg::RES_BAD_PARAM; // RULE7
                  end else if (fss_frozen(r_reg.param, lvl)) begin
                     res = fss_pkg::RES_LOCKED; // RULE11 RULE18
                  end else begin
                     r_next.cells[ci] = fss_pkg::ERASED; // RULE7
                  end
               end
               fss_pkg::FN_READ_CELL: begin
                  case (r_reg.param) // RULE8
                     fss_pkg::CELL_MFR:  res = MFR_ID;
                     fss_pkg::CELL_DEV1: res = DEV_ID1;
                     fss_pkg::CELL_DEV2: res = DEV_ID2;
                     fss_pkg::CELL_BSW_LO, fss_pkg::CELL_BSW_HI, fss_pkg::CELL_BV_LO,
                     fss_pkg::CELL_BV_HI, fss_pkg::CELL_STATUS, fss_pkg::CELL_LOCK1,
                     fss_pkg::CELL_LOCK2, fss_pkg::CELL_LOCK3: res = r_reg.cells[ci];
                     // Holes in the cell map read back as a parameter error
                     default: begin
                        res = fss_pkg::RES_BAD_PARAM;
                        r_next.err = 1'b1;
                     end
                  endcase
               end
               default: begin
                  res = fss_pkg::RES_BAD_FUNC; // RULE17
               end
            endcase
            // Cell work and refusals finish in this one cycle
            if (fin) begin
               r_next.value = res; // RULE2
               if (r_reg.func != fss_pkg::FN_READ_CELL) begin
                  r_next.err = (res != fss_pkg::RES_PASS);
               end
               r_next.done  = 1'b1;
               r_next.state = fss_pkg::FSS_IDLE;
            end
         end
         fss_pkg::FSS_WAIT: begin
            // Request, op and block hold still until the array answers
            if (FLASH_RSP.done) begin
               r_next.cmd.req = 1'b0;
               r_next.value   = FLASH_RSP.fail ? fss_pkg::RES_FLASH_FAIL
                                               : fss_pkg::RES_PASS; // RULE2
               r_next.err     = FLASH_RSP.fail;
               r_next.done    = 1'b1;
               r_next.state   = fss_pkg::FSS_IDLE;
               // A failed erase leaves every cell, locks included, as it was
               if (r_reg.cmd.op == fss_pkg::FSS_OP_CHIP_ERASE && !FLASH_RSP.fail) begin
                  // Chip erase also wipes special cells, so all locks clear
                  for (int i = 0; i < 16; i++) begin
                     r_next.cells[i] = fss_pkg::ERASED; // RULE15
                  end
                  r_next.chip_rst = r_reg.reset_after; // RULE4
               end
               r_next.reset_after = 1'b0; // RULE3
            end
         end
         default: begin
            r_next.state = fss_pkg::FSS_IDLE;
         end
      endcase
   end

   // Cell store is loaded erased at reset; it stands in for the nonvolatile array
   always_ff @(posedge SYS_CLK or posedge RST) begin
      if (RST) begin
         r_reg             <= '0;
         r_reg.state       <= fss_pkg::FSS_IDLE;
         r_reg.cells       <= {16{fss_pkg::ERASED}};
      end else begin
         r_reg <= r_next;
      end
   end

   assign APB_RSP       = r_reg.rsp;
   assign FLASH_CMD     = r_reg.cmd;
   assign CHIP_RESET    = r_reg.chip_rst;
   assign VERIFY_LOCK   = r_reg.verify_lock;
   assign EXT_EXEC_LOCK = r_reg.ext_lock;

endmodule

// ==== tb/fss_flash_service_assertions.sv ====
/*
 Port checker for the flash service block.
 Assumes a bind onto fss_flash_service.
*/
`timescale 1ns/1ps
module fss_flash_service_checker (
   input wire logic                    SYS_CLK,
   input wire logic                    RST,
   input wire fss_pkg::fss_apb_req_t   APB_REQ,
   input wire fss_pkg::fss_apb_rsp_t   APB_RSP,
   input wire fss_pkg::fss_flash_cmd_t FLASH_CMD,
   input wire fss_pkg::fss_flash_rsp_t FLASH_RSP,
   input wire logic                    CHIP_RESET,
   input wire logic                    VERIFY_LOCK,
   input wire logic                    EXT_EXEC_LOCK
);
   logic ok_reg;
   // Registered so the pulse can be tied to the finished erase
   always_ff @(posedge SYS_CLK or posedge RST) begin
      if (RST) begin
         ok_reg <= 1'b0;
      end else begin
         ok_reg <= FLASH_CMD.req && FLASH_RSP.done && !FLASH_RSP.fail
                   && FLASH_CMD.op == fss_pkg::FSS_OP_CHIP_ERASE;
      end
   end
   default clocking @(posedge SYS_CLK); endclocking
   default disable iff (RST);
   a_ready_next: assert property (APB_REQ.psel && APB_REQ.penable && !APB_RSP.pready
      |=> APB_RSP.pready) else $error("pready late");
   a_ready_pulse: assert property (APB_RSP.pready |=> !APB_RSP.pready)
      else $error("pready held");
   a_req_hold: assert property (FLASH_CMD.req && !FLASH_RSP.done |=> FLASH_CMD.req
      && $stable(FLASH_CMD.op) && $stable(FLASH_CMD.block)) else $error("req dropped");
   a_req_drop: assert property (FLASH_CMD.req && FLASH_RSP.done |=> !FLASH_CMD.req)
      else $error("req kept");
   a_reset_cause: assert property (CHIP_RESET |-> ok_reg)
      else $error("reset pulse without erase");
   a_reset_once: assert property (CHIP_RESET |=> !CHIP_RESET)
      else $error("reset pulse long");
   a_exec_level: assert property (EXT_EXEC_LOCK |-> VERIFY_LOCK)
      else $error("level 4 without level 3");
   a_lock_fall: assert property ($fell(VERIFY_LOCK) |-> ok_reg || $past(ok_reg))
      else $error("lock cleared without erase");
endmodule

// ==== tb/fss_flash_model.sv ====
/*
 Flash array controller model for the flash service block.
 Assumes the same clock; latency and failure come from the bench.
*/
`timescale 1ns/1ps
module fss_flash_model (
   input  wire logic                    clk,
   input  wire logic                    rst,
   input  wire fss_pkg::fss_flash_cmd_t cmd,
   input  wire logic [3:0]              lat,
   input  wire logic                    fail_in,
   output      fss_pkg::fss_flash_rsp_t rsp
);
   logic [3:0] cnt_reg;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cnt_reg <= 4'h0;
         rsp     <= '0;
      end else begin
         rsp.done <= 1'b0;
         rsp.fail <= ~rsp.fail; // Meaningless outside done, so keep it moving
         if (cmd.req && !rsp.done && cnt_reg == lat) begin
            rsp.done <= 1'b1;
            rsp.fail <= fail_in;
            cnt_reg  <= 4'h0;
         end else if (cmd.req && !rsp.done) begin
            cnt_reg <= cnt_reg + 4'h1;
         end else begin
            cnt_reg <= 4'h0;
         end
      end
   end
endmodule

// ==== tb/fss_flash_service_bench.sv ====
/*
 Self-checking bench for the flash service block.
 Assumes the checker and flash model are compiled first.
*/
`timescale 1ns/1ps
module fss_flash_service_bench;
   typedef struct packed {
      logic [7:0]  fn;
      logic [15:0] prm;
      logic [7:0]  val;
      logic [7:0]  res;
   } fss_row_t;
   localparam logic [7:0] MFR = 8'h3C; // Arbitrary value
   localparam logic [7:0] DV1 = 8'h41; // Arbitrary value
   localparam logic [7:0] DV2 = 8'h42; // Arbitrary value
   logic                    sys_clk = 1'b0;
   logic                    rst     = 1'b1;
   fss_pkg::fss_apb_req_t   apb_req = '0;
   fss_pkg::fss_apb_rsp_t   apb_rsp;
   fss_pkg::fss_flash_cmd_t flash_cmd;
   fss_pkg::fss_flash_rsp_t flash_rsp;
   logic                    chip_reset;
   logic                    verify_lock;
   logic                    ext_exec_lock;
   logic [3:0]              lat     = 4'h0;
   logic                    fail_in = 1'b0;
   int                      n_fail  = 0;
   int                      n_tests = 0;
   int                      n_pulse = 0;
   logic [31:0]             rdat;
   logic                    rerr;
   logic [7:0]              res;
   logic                    ferr;
   logic                    ferr_exp;
   logic [2:0]              blk_seen;
   fss_row_t                rows [21];
   fss_flash_service #(.MFR_ID(MFR), .DEV_ID1(DV1), .DEV_ID2(DV2)) u_dut (
      .SYS_CLK(sys_clk), .RST(rst), .APB_REQ(apb_req), .APB_RSP(apb_rsp),
      .FLASH_CMD(flash_cmd), .FLASH_RSP(flash_rsp), .CHIP_RESET(chip_reset),
      .VERIFY_LOCK(verify_lock), .EXT_EXEC_LOCK(ext_exec_lock));
   fss_flash_model u_flash (.clk(sys_clk), .rst(rst), .cmd(flash_cmd), .lat(lat),
      .fail_in(fail_in), .rsp(flash_rsp));
   always #2.5 sys_clk = ~sys_clk;
   always @(posedge sys_clk) if (chip_reset === 1'b1) n_pulse++;
   always @(posedge sys_clk) if (flash_cmd.req === 1'b1) blk_seen <= flash_cmd.block;
   task automatic results();
      $display("tests %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task automatic ck(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_fail++;
         $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int k;
      k = 0;
      @(posedge sys_clk);
      apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
      @(posedge sys_clk);
      apb_req.penable <= 1'b1;
      do begin
         @(posedge sys_clk);
         k++;
      end while (apb_rsp.pready !== 1'b1 && k < 50);
      if (apb_rsp.pready !== 1'b1) begin
         n_fail++;
         results();
      end
      rdat = apb_rsp.prdata;
      rerr = apb_rsp.pslverr;
      apb_req.psel    <= 1'b0;
      apb_req.penable <= 1'b0;
   endtask
   // Busy is polled before anything else touches the block
   task automatic run(input logic [7:0] f, input logic [15:0] p, input logic [7:0] v);
      int k;
      k = 0;
      apb(1'b1, fss_pkg::ADDR_FUNC, {24'h00_0000, f});
      apb(1'b1, fss_pkg::ADDR_PARAM, {16'h0000, p});
      apb(1'b1, fss_pkg::ADDR_VALUE, {24'h00_0000, v});
      apb(1'b1, fss_pkg::ADDR_CTRL, 32'h0000_0001);
      do begin
         apb(1'b0, fss_pkg::ADDR_CTRL, 32'h0000_0000);
         k++;
      end while (rdat[1:0] !== 2'b10 && k < 100);
      if (rdat[1:0] !== 2'b10) begin
         n_fail++;
         results();
      end
      ferr = rdat[2];
      apb(1'b0, fss_pkg::ADDR_VALUE, 32'h0000_0000);
      res = rdat[7:0];
      $display("op %h %h %h gives %h", f, p, v, res);
   endtask
   task automatic lvl(input logic [2:0] e);
      apb(1'b0, fss_pkg::ADDR_CTRL, 32'h0000_0000);
      ck(rdat[6:4], e);
   endtask
   initial begin
      rows = '{'{8'h96, 16'h0006, 8'h00, MFR}, '{8'h96, 16'h0007, 8'h00, DV1},
         '{8'h96, 16'h0008, 8'h00, DV2}, '{8'h96, 16'h0004, 8'h00, 8'hFF},
         '{8'h96, 16'h0005, 8'h00, 8'h03}, '{8'h97, 16'h0000, 8'h00, 8'h01},
         '{8'h90, 16'h0000, 8'h00, 8'h00}, '{8'h90, 16'h2000, 8'h00, 8'h00},
         '{8'h90, 16'h4000, 8'h00, 8'h00}, '{8'h90, 16'h8000, 8'h00, 8'h00},
         '{8'h90, 16'hC000, 8'h00, 8'h00}, '{8'h94, 16'h0002, 8'hFE, 8'h00},
         '{8'h96, 16'h0002, 8'h00, 8'hFE}, '{8'h94, 16'h0002, 8'hFD, 8'h00},
         '{8'h96, 16'h0002, 8'h00, 8'hFC}, '{8'h95, 16'h0002, 8'h00, 8'h00},
         '{8'h96, 16'h0002, 8'h00, 8'hFF}, '{8'h95, 16'h000A, 8'h00, 8'h03},
         '{8'h91, 16'h0000, 8'h12, 8'h03}, '{8'h91, 16'h0000, 8'h55, 8'h00},
         '{8'h96, 16'h000A, 8'h00, 8'hFF}};
      repeat (2) @(posedge sys_clk);
      rst <= 1'b0;
      lvl(3'h1);
      ck(rdat, 32'h0000_0010);
      apb(1'b1, 12'h010, 32'h0000_00FF);
      ck(rerr, 1'b1);
      for (int i = 0; i < 21; i++) begin
         lat <= i[3:0];
         run(rows[i].fn, rows[i].prm, rows[i].val);
         ck(res, rows[i].res);
         ferr_exp = (rows[i].fn != 8'h96 && rows[i].res != 8'h00) || rows[i].prm == 16'h0005;
         ck(ferr, ferr_exp);
         if (i >= 6 && i <= 10) ck(blk_seen, i - 6);
      end
      ck(n_pulse, 0);
      // Locks set in the defined order only
      run(8'h94, 16'h000A, 8'hFE);
      lvl(3'h2);
      run(8'h90, 16'h4000, 8'h00);
      ck(res !== 8'h00, 1'b1);
      run(8'h94, 16'h0003, 8'hFE);
      ck(res !== 8'h00, 1'b1);
      run(8'h95, 16'h0004, 8'h00);
      ck(res !== 8'h00, 1'b1);
      run(8'h96, 16'h0003, 8'h00);
      ck(res, 8'hFF);
      run(8'h94, 16'h000C, 8'hFE);
      lvl(3'h3);
      ck({ext_exec_lock, verify_lock}, 2'b01);
      run(8'h94, 16'h000E, 8'hFE);
      lvl(3'h4);
      ck({ext_exec_lock, verify_lock}, 2'b11);
      run(8'h94, 16'h0000, 8'hFD);
      ck(res, 8'h00);
      run(8'h96, 16'h0000, 8'h00);
      ck(res, 8'hFD);
      // Failed erase must keep every lock
      fail_in <= 1'b1;
      run(8'h91, 16'h0000, 8'hAA);
      ck(res !== 8'h00, 1'b1);
      lvl(3'h4);
      ck(n_pulse, 0);
      fail_in <= 1'b0;
      lat     <= 4'hF;
      run(8'h91, 16'h0000, 8'hAA);
      ck(res, 8'h00);
      ck(n_pulse, 1);
      lvl(3'h1);
      run(8'h94, 16'h000A, 8'hFE);
      rst <= 1'b1;
      repeat (2) @(posedge sys_clk);
      rst <= 1'b0;
      lvl(3'h1);
      ck(rdat, 32'h0000_0010);
      results();
   end
endmodule
bind fss_flash_service fss_flash_service_checker u_chk (.SYS_CLK(SYS_CLK), .RST(RST),
   .APB_REQ(APB_REQ), .APB_RSP(APB_RSP), .FLASH_CMD(FLASH_CMD), .FLASH_RSP(FLASH_RSP),
   .CHIP_RESET(CHIP_RESET), .VERIFY_LOCK(VERIFY_LOCK), .EXT_EXEC_LOCK(EXT_EXEC_LOCK));
